// *** rtl/dmt_pkg.sv ***
// dmt_pkg: register map, field layout, reset values and decode helpers
// for the demodulator tuning register bank.
// assumes an 8-bit register port driven by the device's serial front end.
package dmt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_PDF_SETUP = 8'h03;
  localparam logic [7:0] OFS_THR_FLOOR = 8'h04;
  localparam logic [7:0] OFS_THR_TIMING = 8'h05;
  localparam logic [7:0] OFS_THR_METHOD = 8'h06;
  localparam logic [7:0] OFS_FREQ_CORR = 8'h07;

  // reset values
  localparam logic [7:0] RST_PDF_SETUP = 8'h10;
  localparam logic [7:0] RST_THR_FLOOR = 8'h00;
  localparam logic [7:0] RST_THR_TIMING = 8'h10;
  localparam logic [7:0] RST_THR_METHOD = 8'h0f;
  localparam logic [7:0] RST_FREQ_CORR = 8'h02;

  // implemented bits of each register
  localparam logic [7:0] MASK_PDF_SETUP = 8'hff;
  localparam logic [7:0] MASK_THR_FLOOR = 8'hff;
  localparam logic [7:0] MASK_THR_TIMING = 8'h7f;
  localparam logic [7:0] MASK_THR_METHOD = 8'h7f;
  localparam logic [7:0] MASK_FREQ_CORR = 8'h1f;

  // field positions
  localparam int LOW_DELAY_BIT = 7;
  localparam int BW_BOOST_BIT = 6;
  localparam int COARSE_LSB = 3;
  localparam int FINE_LSB = 0;
  localparam int PEAK_HOLD_LSB = 5;
  localparam int TIME_CONST_LSB = 0;
  localparam int METHOD_BIT = 6;
  localparam int PREFILTER_BIT = 5;
  localparam int GAIN_CONST_LSB = 0;
  localparam int OFFSET_LIMIT_LSB = 2;
  localparam int LOOP_GAIN_LSB = 0;

  // decode constants
  localparam logic [2:0] COARSE_DEFAULT_CODE = 3'h2;
  localparam logic [2:0] LOW_DELAY_MIN_COARSE = 3'h3;
  localparam logic [3:0] FINE_DIV_BASE = 4'h8;
  localparam logic [7:0] BW_DEFAULT_PCT = 8'h64;
  localparam logic [7:0] BW_BOOST_PCT = 8'ha7;
  localparam logic [2:0] LOOP_GAIN_DEFAULT_CODE = 3'h2;
  localparam logic [3:0] ONE_X = 4'h1;

  // write merge: only implemented bits take the new value
  function automatic logic [7:0] wr_merge(input logic [7:0] wdata, input logic [7:0] mask);
    return wdata & mask;
  endfunction : wr_merge

  // log2 of the coarse rate factor, code 2 is 0
  function automatic logic [3:0] coarse_log2(input logic [2:0] code);
    return 4'({1'b0, COARSE_DEFAULT_CODE} - {1'b0, code});
  endfunction : coarse_log2

  // log2 of the loop gain factor, code 2 is 0
  function automatic logic [2:0] loop_gain_log2(input logic [1:0] code);
    return 3'({1'b0, code} - LOOP_GAIN_DEFAULT_CODE);
  endfunction : loop_gain_log2

  // low-delay output is only valid for these rate steps
  function automatic logic low_delay_legal(input logic [2:0] coarse, input logic [2:0] fine);
    return (coarse >= LOW_DELAY_MIN_COARSE) || ((coarse == COARSE_DEFAULT_CODE) && !fine[0]);
  endfunction : low_delay_legal

endpackage : dmt_pkg

// *** rtl/dmt_cfg_if.sv ***
// dmt_cfg_if: raw configuration fields out of the bank and their
// decoded factors back from the decoder.
// assumes both ends sit on the same clock.
`timescale 1ns/1ps
interface dmt_cfg_if;
  // raw fields
  logic low_delay_sel;
  logic bw_boost;
  logic [2:0] coarse;
  logic [2:0] fine;
  logic [1:0] peak_hold;
  logic method_sel;
  logic prefilter_bw;
  logic [2:0] offset_limit;
  logic [1:0] loop_gain;
  // decoded factors
  logic [7:0] bw_pct;
  logic [3:0] coarse_log2;
  logic [3:0] fine_div;
  logic [3:0] peak_mult;
  logic [1:0] prefilter_mult;
  logic afc_enable;
  logic [2:0] loop_gain_log2;
  logic low_delay_ok;

  modport dec (
    input low_delay_sel, bw_boost, coarse, fine, peak_hold, method_sel, prefilter_bw,
    input offset_limit, loop_gain,
    output bw_pct, coarse_log2, fine_div, peak_mult, prefilter_mult, afc_enable,
    output loop_gain_log2, low_delay_ok
  );
  modport bank (
    output low_delay_sel, bw_boost, coarse, fine, peak_hold, method_sel, prefilter_bw,
    output offset_limit, loop_gain,
    input bw_pct, coarse_log2, fine_div, peak_mult, prefilter_mult, afc_enable,
    input loop_gain_log2, low_delay_ok
  );
endinterface : dmt_cfg_if

// *** rtl/dmt_decode.sv ***
// dmt_decode: turns raw configuration codes into scaling factors.
// assumes fields come from registers of the bank; purely combinational.
`timescale 1ns/1ps
module dmt_decode (
  dmt_cfg_if.dec cfg
);
  // filter bandwidth in percent of default
  assign cfg.bw_pct = cfg.bw_boost ? dmt_pkg::BW_BOOST_PCT : dmt_pkg::BW_DEFAULT_PCT;
  // rate factor as a signed power of two, +2 down to -5
  assign cfg.coarse_log2 = dmt_pkg::coarse_log2(cfg.coarse);
  // rate reduced by 8/(8+n): hand out the divisor
  assign cfg.fine_div = dmt_pkg::FINE_DIV_BASE + {1'b0, cfg.fine};
  // discharge time multiplier 1,2,4,8
  assign cfg.peak_mult = 4'(dmt_pkg::ONE_X << cfg.peak_hold);
  // prefilter bandwidth multiplier 1 or 2
  assign cfg.prefilter_mult = cfg.prefilter_bw ? 2'h2 : 2'h1;
  // zero limit turns the loop off
  assign cfg.afc_enable = (cfg.offset_limit != 3'h0);
  assign cfg.loop_gain_log2 = dmt_pkg::loop_gain_log2(cfg.loop_gain);
  assign cfg.low_delay_ok = dmt_pkg::low_delay_legal(cfg.coarse, cfg.fine);
endmodule : dmt_decode

// *** rtl/dmt_regs.sv ***
// dmt_regs: demodulator tuning register bank with decoded control outputs.
// assumes a same-clock register port from the serial front end: at most
// one write and one read per cycle, address and data valid with the strobe.
`timescale 1ns/1ps
module dmt_regs (
  // clock and control
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // register port
  input wire logic [dmt_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [dmt_pkg::DATA_W-1:0] reg_wdata_in,
  output logic [dmt_pkg::DATA_W-1:0] reg_rdata_out,
  // post-demodulation filter controls
  output logic low_delay_sel_out,
  output logic low_delay_ok_out,
  output logic [7:0] pdf_bw_pct_out,
  output logic signed [3:0] rate_coarse_log2_out,
  output logic [3:0] rate_fine_div_out,
  // ask threshold controls
  output logic signed [7:0] threshold_floor_out,
  output logic [3:0] peak_hold_mult_out,
  output logic [4:0] threshold_time_const_out,
  output logic threshold_method_sel_out,
  output logic [1:0] prefilter_bw_mult_out,
  output logic [4:0] threshold_gain_const_out,
  // frequency control
  output logic afc_enable_out,
  output logic [2:0] offset_limit_out,
  output logic signed [2:0] loop_gain_log2_out
);

  logic [7:0] pdf_reg;
  logic [7:0] floor_reg;
  logic [7:0] timing_reg;
  logic [7:0] method_reg;
  logic [7:0] afc_reg;
  logic [7:0] rdata_next;

  dmt_cfg_if cfg ();

  dmt_decode u_decode (
    .cfg(cfg.dec)
  );

  // raw fields to the decoder
  assign cfg.low_delay_sel = pdf_reg[dmt_pkg::LOW_DELAY_BIT];
  assign cfg.bw_boost = pdf_reg[dmt_pkg::BW_BOOST_BIT];
  assign cfg.coarse = pdf_reg[dmt_pkg::COARSE_LSB +: 3];
  assign cfg.fine = pdf_reg[dmt_pkg::FINE_LSB +: 3];
  assign cfg.peak_hold = timing_reg[dmt_pkg::PEAK_HOLD_LSB +: 2];
  assign cfg.method_sel = method_reg[dmt_pkg::METHOD_BIT];
  assign cfg.prefilter_bw = method_reg[dmt_pkg::PREFILTER_BIT];
  assign cfg.offset_limit = afc_reg[dmt_pkg::OFFSET_LIMIT_LSB +: 3];
  assign cfg.loop_gain = afc_reg[dmt_pkg::LOOP_GAIN_LSB +: 2];

  // register writes; unused bits never store
  // masked field storage
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pdf_reg <= dmt_pkg::RST_PDF_SETUP;
      floor_reg <= dmt_pkg::RST_THR_FLOOR;
      timing_reg <= dmt_pkg::RST_THR_TIMING;
      method_reg <= dmt_pkg::RST_THR_METHOD;
      afc_reg <= dmt_pkg::RST_FREQ_CORR;
    end else if (ce_in && reg_wr_in) begin
      unique case (reg_addr_in)
        dmt_pkg::OFS_PDF_SETUP: begin
          pdf_reg <= dmt_pkg::wr_merge(reg_wdata_in, dmt_pkg::MASK_PDF_SETUP);
        end
        dmt_pkg::OFS_THR_FLOOR: begin
          floor_reg <= dmt_pkg::wr_merge(reg_wdata_in, dmt_pkg::MASK_THR_FLOOR);
        end
        dmt_pkg::OFS_THR_TIMING: begin
          timing_reg <= dmt_pkg::wr_merge(reg_wdata_in, dmt_pkg::MASK_THR_TIMING);
        end
        dmt_pkg::OFS_THR_METHOD: begin
          method_reg <= dmt_pkg::wr_merge(reg_wdata_in, dmt_pkg::MASK_THR_METHOD);
        end
        dmt_pkg::OFS_FREQ_CORR: begin
          afc_reg <= dmt_pkg::wr_merge(reg_wdata_in, dmt_pkg::MASK_FREQ_CORR);
        end
        default: begin
          // other offsets belong to other banks
        end
      endcase
    end
  end

  // read mux; unmapped offsets answer zero
  always_comb begin
    unique case (reg_addr_in)
      dmt_pkg::OFS_PDF_SETUP: rdata_next = pdf_reg;
      dmt_pkg::OFS_THR_FLOOR: rdata_next = floor_reg;
      dmt_pkg::OFS_THR_TIMING: rdata_next = timing_reg;
      dmt_pkg::OFS_THR_METHOD: rdata_next = method_reg;
      dmt_pkg::OFS_FREQ_CORR: rdata_next = afc_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data holds until the next read
  // value of the last read
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      reg_rdata_out <= rdata_next;
    end
  end

  // filter controls, one cycle behind the fields so outputs are flops
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      low_delay_sel_out <= 1'b0;
      low_delay_ok_out <= 1'b1;
      pdf_bw_pct_out <= dmt_pkg::BW_DEFAULT_PCT;
      rate_coarse_log2_out <= 4'h0;
      rate_fine_div_out <= dmt_pkg::FINE_DIV_BASE;
    end else if (ce_in) begin
      low_delay_sel_out <= cfg.low_delay_sel;
      low_delay_ok_out <= cfg.low_delay_ok;
      pdf_bw_pct_out <= cfg.bw_pct;
      rate_coarse_log2_out <= cfg.coarse_log2;
      rate_fine_div_out <= cfg.fine_div;
    end
  end

  // threshold generator controls; timing and gain pass as the host set them
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      threshold_floor_out <= dmt_pkg::RST_THR_FLOOR;
      peak_hold_mult_out <= dmt_pkg::ONE_X;
      threshold_time_const_out <= dmt_pkg::RST_THR_TIMING[dmt_pkg::TIME_CONST_LSB +: 5];
      threshold_method_sel_out <= 1'b0;
      prefilter_bw_mult_out <= 2'h1;
      threshold_gain_const_out <= dmt_pkg::RST_THR_METHOD[dmt_pkg::GAIN_CONST_LSB +: 5];
    end else if (ce_in) begin
      threshold_floor_out <= signed'(floor_reg);
      peak_hold_mult_out <= cfg.peak_mult;
      threshold_time_const_out <= timing_reg[dmt_pkg::TIME_CONST_LSB +: 5];
      threshold_method_sel_out <= cfg.method_sel;
      prefilter_bw_mult_out <= cfg.prefilter_mult;
      threshold_gain_const_out <= method_reg[dmt_pkg::GAIN_CONST_LSB +: 5];
    end
  end

  // frequency control loop settings
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      afc_enable_out <= 1'b0;
      offset_limit_out <= 3'h0;
      loop_gain_log2_out <= 3'h0;
    end else if (ce_in) begin
      afc_enable_out <= cfg.afc_enable;
      offset_limit_out <= cfg.offset_limit;
      loop_gain_log2_out <= cfg.loop_gain_log2;
    end
  end

  // checks on the bank; all in the core clock domain
  default clocking dmt_cb @(posedge core_clk_in);
  endclocking
  default disable iff (rst_in);

  a_bw_boost: assert property (ce_in |=> pdf_bw_pct_out ==
    ($past(pdf_reg[dmt_pkg::BW_BOOST_BIT]) ? 8'ha7 : 8'h64))
    else $error("bandwidth factor does not follow boost bit");
  a_coarse_rate: assert property (ce_in |=>
    rate_coarse_log2_out == signed'(4'(4'h2 - {1'b0, $past(pdf_reg[5:3])})))
    else $error("coarse rate factor wrong");
  a_fine_div: assert property (ce_in |=>
    rate_fine_div_out == 4'h8 + {1'b0, $past(pdf_reg[2:0])})
    else $error("fine rate divisor wrong");
  a_floor_signed: assert property ((ce_in && reg_wr_in && reg_addr_in == 8'h04)
    ##1 ce_in |=> threshold_floor_out == signed'($past(reg_wdata_in, 2)))
    else $error("threshold floor not passed through");
  a_peak_hold: assert property (ce_in |=>
    peak_hold_mult_out == 4'(4'h1 << $past(timing_reg[6:5])))
    else $error("peak hold multiplier wrong");
  a_method_sel: assert property (ce_in |=>
    threshold_method_sel_out == $past(method_reg[6]))
    else $error("threshold method not applied");
  a_prefilter_bw: assert property (ce_in |=>
    prefilter_bw_mult_out == ($past(method_reg[5]) ? 2'h2 : 2'h1))
    else $error("prefilter bandwidth wrong");
  a_afc_off: assert property ((ce_in && afc_reg[4:2] == 3'h0) |=> !afc_enable_out)
    else $error("frequency control on with zero limit");
  a_afc_on: assert property ((ce_in && afc_reg[4:2] != 3'h0) |=>
    afc_enable_out && offset_limit_out == $past(afc_reg[4:2]))
    else $error("frequency control limit not applied");
  a_loop_gain: assert property (ce_in |=>
    loop_gain_log2_out == signed'(3'({1'b0, $past(afc_reg[1:0])} - 3'h2)))
    else $error("loop gain factor wrong");
  a_readback_afc: assert property ((ce_in && reg_wr_in && reg_addr_in == 8'h07)
    ##1 (ce_in && reg_rd_in && !reg_wr_in && reg_addr_in == 8'h07)
    |=> reg_rdata_out == ($past(reg_wdata_in, 2) & 8'h1f))
    else $error("readback differs from masked write");
  a_freeze_ce: assert property (!ce_in |=>
    $stable(pdf_reg) && $stable(afc_reg) && $stable(reg_rdata_out))
    else $error("state moved while clock enable low");

  c_boost_on: cover property (pdf_bw_pct_out == 8'ha7);
  c_low_delay_legal: cover property (low_delay_sel_out && low_delay_ok_out);
  c_afc_on: cover property (afc_enable_out && loop_gain_log2_out == 3'h1);
  c_peak_det: cover property (threshold_method_sel_out && peak_hold_mult_out == 4'h8);

endmodule : dmt_regs

// *** testbench/dmt_host_model.sv ***
// dmt_host_model: host controller behind the register port of the bank.
// assumes the caller starts every task on a rising clock edge.
`timescale 1ns/1ps
module dmt_host_model (
  // clock
  input wire logic core_clk_in,
  // register port towards the bank
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out,
  input wire logic [7:0] reg_rdata_in
);
  // idle port at time zero
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end

  function automatic logic legal(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h03) return !d[7] || d[5:3] >= 3'h3 || (d[5:3] == 3'h2 && !d[0]);
    if (a == 8'h04) return d[7] || d == 8'h00;
    return 1'b1;
  endfunction : legal

  // one port cycle; hold keeps strobes up for a back-to-back cycle
  task automatic xfer(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d,
                      input logic hold);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= w;
    reg_rd_out <= r;
    @(posedge core_clk_in);
    if (!hold) begin
      reg_wr_out <= 1'b0;
      reg_rd_out <= 1'b0;
      // released lines do not keep the old value
      reg_addr_out <= ~a;
      reg_wdata_out <= ~d;
    end
  endtask : xfer

  task automatic write(input logic [7:0] a, input logic [7:0] d);
    if (legal(a, d)) begin
      @(posedge core_clk_in);
      xfer(1'b1, 1'b0, a, d, 1'b0);
    end
  endtask : write

  // read data is sampled a full cycle after the taking edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    xfer(1'b0, 1'b1, a, 8'h00, 1'b0);
    @(posedge core_clk_in);
    #1;
    d = reg_rdata_in;
  endtask : read
endmodule : dmt_host_model

// *** testbench/dmt_regs_bench.sv ***
// dmt_regs_bench: self-checking bench for the tuning register bank.
// assumes the host model drives the register port; bench owns clock, reset, enable.
`timescale 1ns/1ps
module dmt_regs_bench;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] rb;} dmt_row_t;
  logic core_clk_in, rst_in, ce_in, wr, rd, ld_sel, ld_ok, meth, afc_en;
  logic [7:0] addr, wdata, rdata, bw, got;
  logic signed [7:0] flr;
  logic signed [3:0] crs;
  logic [3:0] fdiv, peak;
  logic [4:0] tc, gain;
  logic [1:0] pref;
  logic [2:0] lim;
  logic signed [2:0] lg;
  logic [49:0] obs;
  logic [7:0] sh [8];
  int failures, checked;
  localparam logic [7:0] RSTV [8] = '{8'h00, 8'h00, 8'h00, 8'h10, 8'h00, 8'h10, 8'h0f, 8'h02};
  localparam dmt_row_t ROWS [29] = '{
    '{8'h03, 8'h07, 8'h07}, '{8'h03, 8'h4e, 8'h4e}, '{8'h03, 8'h15, 8'h15},
    '{8'h03, 8'h9c, 8'h9c}, '{8'h03, 8'h23, 8'h23}, '{8'h03, 8'h6a, 8'h6a},
    '{8'h03, 8'h31, 8'h31}, '{8'h03, 8'hb8, 8'hb8}, '{8'h03, 8'hd2, 8'hd2},
    '{8'h03, 8'h12, 8'h12}, '{8'h04, 8'h80, 8'h80}, '{8'h04, 8'hff, 8'hff},
    '{8'h04, 8'h00, 8'h00}, '{8'h05, 8'hff, 8'h7f}, '{8'h05, 8'h20, 8'h20},
    '{8'h05, 8'h45, 8'h45}, '{8'h06, 8'hff, 8'h7f}, '{8'h06, 8'h00, 8'h00},
    '{8'h07, 8'hff, 8'h1f}, '{8'h07, 8'h05, 8'h05}, '{8'h07, 8'h08, 8'h08},
    '{8'h07, 8'h0e, 8'h0e}, '{8'h07, 8'h10, 8'h10}, '{8'h07, 8'h16, 8'h16},
    '{8'h07, 8'h18, 8'h18}, '{8'h07, 8'h00, 8'h00}, '{8'h08, 8'h55, 8'h00},
    '{8'h02, 8'haa, 8'h00}, '{8'hff, 8'hff, 8'h00}};

  assign obs = {ld_sel, ld_ok, bw, crs, fdiv, flr, peak, tc, meth, pref, gain, afc_en, lim, lg};

  dmt_host_model host_u (.core_clk_in(core_clk_in), .reg_addr_out(addr), .reg_wr_out(wr),
    .reg_rd_out(rd), .reg_wdata_out(wdata), .reg_rdata_in(rdata));

  dmt_regs dut_u (.core_clk_in(core_clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata),
    .reg_rdata_out(rdata), .low_delay_sel_out(ld_sel), .low_delay_ok_out(ld_ok),
    .pdf_bw_pct_out(bw), .rate_coarse_log2_out(crs), .rate_fine_div_out(fdiv),
    .threshold_floor_out(flr), .peak_hold_mult_out(peak), .threshold_time_const_out(tc),
    .threshold_method_sel_out(meth), .prefilter_bw_mult_out(pref),
    .threshold_gain_const_out(gain), .afc_enable_out(afc_en), .offset_limit_out(lim),
    .loop_gain_log2_out(lg));

  // expected controls worked out from the shadow registers
  function automatic logic [49:0] calc();
    logic [7:0] p, t, m, a;
    p = sh[3];
    t = sh[5];
    m = sh[6];
    a = sh[7];
    return {p[7], (p[5:3] >= 3'h3) || (p[5:3] == 3'h2 && !p[0]), p[6] ? 8'ha7 : 8'h64,
      4'(4'h2 - {1'b0, p[5:3]}), 4'(4'h8 + {1'b0, p[2:0]}), sh[4], 4'(4'h1 << t[6:5]),
      t[4:0], m[6], m[5] ? 2'h2 : 2'h1, m[4:0], a[4:2] != 3'h0, a[4:2],
      3'({1'b0, a[1:0]} - 3'h2)};
  endfunction : calc

  task automatic cmp_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_reg

  task automatic cmp_ctl(input string n, input logic [49:0] e, input logic [49:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp_ctl

  // reads every register back against its reset value
  task automatic check_reset();
    for (int i = 3; i < 8; i++) begin
      sh[i] = RSTV[i];
      host_u.read(8'(i), got);
      cmp_reg("reset value", RSTV[i], got);
    end
    cmp_ctl("reset controls", calc(), obs);
  endtask : check_reset

  task automatic final_report();
    $display("checked=%0d failures=%0d", checked, failures);
    if (failures == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report

  // free-running clock
  initial begin
    core_clk_in = 1'b0;
    forever #20 core_clk_in = ~core_clk_in;
  end

  // hang guard, far beyond the couple of hundred cycles of the run
  initial begin
    #800000;
    failures++;
    final_report();
  end

  // main sequence
  initial begin
    failures = 0;
    checked = 0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'b0;
    check_reset();
    // table of writes, readback and decoded controls
    foreach (ROWS[i]) begin
      host_u.write(ROWS[i].a, ROWS[i].d);
      host_u.read(ROWS[i].a, got);
      cmp_reg("readback", ROWS[i].rb, got);
      if (ROWS[i].a inside {[8'h03:8'h07]}) sh[ROWS[i].a[2:0]] = ROWS[i].rb;
      cmp_ctl("controls", calc(), obs);
    end
    // a write with the enable low is dropped
    @(posedge core_clk_in);
    ce_in <= 1'b0;
    host_u.write(8'h07, 8'h1d);
    ce_in <= 1'b1;
    host_u.read(8'h07, got);
    cmp_reg("write with enable low", sh[7], got);
    // back-to-back writes, the second with a read in the same cycle
    @(posedge core_clk_in);
    host_u.xfer(1'b1, 1'b0, 8'h07, 8'h1d, 1'b1);
    host_u.xfer(1'b1, 1'b1, 8'h07, 8'h0a, 1'b0);
    @(posedge core_clk_in);
    #1;
    cmp_reg("read during write", 8'h1d, rdata);
    sh[7] = 8'h0a;
    host_u.read(8'h07, got);
    cmp_reg("second write", 8'h0a, got);
    cmp_ctl("controls after burst", calc(), obs);
    // write then read of the same register in the very next cycle
    @(posedge core_clk_in);
    host_u.xfer(1'b1, 1'b0, 8'h07, 8'h16, 1'b1);
    host_u.xfer(1'b0, 1'b1, 8'h07, 8'h00, 1'b0);
    @(posedge core_clk_in);
    #1;
    cmp_reg("read right after write", 8'h16, rdata);
    sh[7] = 8'h16;
    cmp_ctl("controls after write-read", calc(), obs);
    // reset in mid-run restores defaults
    @(posedge core_clk_in);
    rst_in <= 1'b1;
    @(posedge core_clk_in);
    rst_in <= 1'b0;
    check_reset();
    final_report();
  end
endmodule : dmt_regs_bench
